// file: rtl/monitor_adc_config_alert_mask.sv
// adc configuration, shunt result and alert mask command registers
//
// Overview of operation
// R1 - reading the adc configuration leaves settings and running conversion untouched
// R2 - writing adc configuration halts conversion, then restarts with new settings
// R3 - sixteen bit configuration; top nibble fixed 0100; resets to 4127h
// R4 - averaging code selects 1,4,16,64,128,256,512,1024 samples; reset code 000
// R5 - bus conversion time bits 8:6, 140 us to 8.244 ms; reset 100
// R6 - shunt conversion time bits 5:3, same steps; reset 100 gives 1.1 ms
// R7 - mode 0/4 power down, 1-3 triggered, 5-7 continuous; reset 111; the sequencer stays idle from reset until the first configuration write
// R8 - shunt result is sixteen bit two's complement, 7fffh is full scale
// R9 - with averaging above one, the shunt result holds the average
// R10 - shunt result fully read only, magnitude in 14:0, resets to zero
// R11 - shunt result uses direct data format only; host reads it so
// R12 - a set mask bit keeps that status bit off the alert pin
// R13 - mask bit 7 gates conversion ready; resets to one
// R14 - mask bit 6 gates adc overflow; resets to one
// R15 - mask bit 5 gates power-on-reset event; resets to one
// R16 - mask bit 4 gates the or of communication faults; resets to one
// R17 - mask bits 3:0 gate power, current, voltage warnings; reset to zero
// R18 - writes to fixed configuration bits are ignored
`timescale 1ns/1ps
module monitor_adc_config_alert_mask #(
  parameter int SHUNT_WIDTH = 16,
  parameter int AVG_MAX_LOG2 = 10,
  parameter logic [7:0][20:0] CONV_CYCLES = monitor_pkg::conv_cycles_default
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input monitor_pkg::host_cmd_type host_cmd_in,
  output monitor_pkg::read_answer_type answer_out,
  output monitor_pkg::adc_config_type adc_config_out,
  input wire logic [SHUNT_WIDTH-1:0] shunt_code_in,
  output logic shunt_sample_out,
  output logic bus_sample_out,
  output logic conversion_ready_out,
  output logic adc_overflow_out,
  output logic powered_down_out,
  output logic conversion_busy_out,
  input wire logic [7:0] vendor_status_flags_in,
  output logic alert_request_out
);

  localparam int CT_WIDTH = 21;
  localparam int ROUND_WIDTH = AVG_MAX_LOG2 + 1;
  localparam int ACC_WIDTH = SHUNT_WIDTH + AVG_MAX_LOG2;

  // ==========================================================
  // elaboration checks
  if (SHUNT_WIDTH != 16) begin : g_bad_width
    $error("shunt result must be sixteen bits wide");
  end
  if (AVG_MAX_LOG2 < 10) begin : g_bad_avg
    $error("accumulator too narrow for 1024 samples");
  end
  for (genvar i = 0; i < 8; i++) begin : g_ct_check
    if (CONV_CYCLES[i] == 21'h0) begin : g_zero
      $error("conversion time entry must be at least one cycle");
    end
  end

  // ==========================================================
  // registers and wires
  monitor_pkg::adc_config_type config_q;
  monitor_pkg::adc_config_type config_d;
  logic [SHUNT_WIDTH-1:0] shunt_result_q;
  logic [7:0] alert_mask_q;
  monitor_pkg::read_answer_type answer_q;
  logic signed [ACC_WIDTH-1:0] acc_q;
  logic signed [ACC_WIDTH-1:0] sum_d;
  logic signed [ACC_WIDTH-1:0] sample_ext;
  logic signed [ACC_WIDTH-1:0] avg_shifted;
  logic [SHUNT_WIDTH-1:0] shunt_result_d;
  logic conversion_ready_q;
  logic adc_overflow_q;
  logic alert_request_q;
  logic [7:0] gated_flags;
  logic [15:0] read_data_d;
  logic read_known;
  logic full_scale;

  logic config_write;
  logic mask_write;
  logic restart;
  logic halt;
  logic run;
  logic continuous;
  logic do_shunt;
  logic do_bus;
  logic [3:0] avg_shift;
  logic [ROUND_WIDTH-1:0] avg_rounds;
  logic [CT_WIDTH-1:0] shunt_cycles;
  logic [CT_WIDTH-1:0] bus_cycles;
  logic shunt_sample;
  logic bus_sample;
  logic set_done;
  logic seq_busy;

  // ==========================================================
  // command decode
  assign config_write = host_cmd_in.write &&
                        host_cmd_in.code == monitor_pkg::cmd_adc_configuration;
  assign mask_write = host_cmd_in.write &&
                      host_cmd_in.code == monitor_pkg::cmd_alert_cause_mask;

  // R2 - halt then restart
  // pending covers the whole host write sequence; commit restarts
  assign halt = host_cmd_in.pending;
  assign restart = config_write;

  // ==========================================================
  // mode decode
  // decoded from the value being committed, so a restart starts in the new mode
  // R7 - mode code meaning
  always_comb begin
    run = 1'b1;
    continuous = 1'b0;
    do_shunt = 1'b0;
    do_bus = 1'b0;
    case (config_d.mode)
      monitor_pkg::mode_shunt_trig: begin
        do_shunt = 1'b1;
      end
      monitor_pkg::mode_bus_trig: begin
        do_bus = 1'b1;
      end
      monitor_pkg::mode_both_trig: begin
        do_shunt = 1'b1;
        do_bus = 1'b1;
      end
      monitor_pkg::mode_shunt_cont: begin
        continuous = 1'b1;
        do_shunt = 1'b1;
      end
      monitor_pkg::mode_bus_cont: begin
        continuous = 1'b1;
        do_bus = 1'b1;
      end
      monitor_pkg::mode_both_cont: begin
        continuous = 1'b1;
        do_shunt = 1'b1;
        do_bus = 1'b1;
      end
      default: begin
        // both power-down codes
        run = 1'b0;
      end
    endcase
  end

  // R4 - averaging sample count
  assign avg_shift = monitor_pkg::avg_shift_table[config_d.sample_averaging_count];
  assign avg_rounds = ROUND_WIDTH'(1) << avg_shift;

  // R5 - bus conversion time
  assign bus_cycles = CONV_CYCLES[config_d.bus_conv_time];

  // R6 - shunt conversion time
  assign shunt_cycles = CONV_CYCLES[config_d.shunt_conv_time];

  // ==========================================================
  // adc configuration register
  // R3 - fixed nibble and reset pattern
  // R18 - fixed bits ignore writes
  always_comb begin
    config_d = config_q;
    if (config_write) begin
      config_d = {monitor_pkg::adc_config_fixed, host_cmd_in.wdata[11:0]};
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      config_q <= monitor_pkg::adc_config_reset;
    end else begin
      config_q <= config_d;
    end
  end

  // ==========================================================
  // alert cause mask register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      alert_mask_q <= monitor_pkg::alert_mask_reset;
    end else if (mask_write) begin
      alert_mask_q <= host_cmd_in.wdata[7:0];
    end
  end

  // ==========================================================
  // conversion timing
  conversion_sequencer #(
    .CT_WIDTH(CT_WIDTH),
    .ROUND_WIDTH(ROUND_WIDTH)
  ) u_sequencer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .restart_in(restart),
    .halt_in(halt),
    .run_in(run),
    .continuous_in(continuous),
    .do_shunt_in(do_shunt),
    .do_bus_in(do_bus),
    .shunt_cycles_in(shunt_cycles),
    .bus_cycles_in(bus_cycles),
    .rounds_in(avg_rounds),
    .shunt_sample_out(shunt_sample),
    .bus_sample_out(bus_sample),
    .set_done_out(set_done),
    .busy_out(seq_busy)
  );

  assign shunt_sample_out = shunt_sample;
  assign bus_sample_out = bus_sample;

  // ==========================================================
  // shunt averaging
  // R8 - sign extended two's complement sum
  assign sample_ext = ACC_WIDTH'($signed(shunt_code_in));
  assign sum_d = shunt_sample ? acc_q + sample_ext : acc_q;

  // R9 - average by arithmetic shift
  // truncates toward minus infinity; cheaper than a rounding adder
  assign avg_shifted = sum_d >>> avg_shift;
  assign shunt_result_d = avg_shifted[SHUNT_WIDTH-1:0];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      acc_q <= '0;
    end else if (restart || set_done) begin
      acc_q <= '0;
    end else if (shunt_sample && !halt) begin
      acc_q <= sum_d;
    end
  end

  // ==========================================================
  // shunt voltage result register
  // R10 - read only, loaded only by conversions
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      shunt_result_q <= monitor_pkg::shunt_result_reset;
    end else if (set_done && do_shunt) begin
      shunt_result_q <= shunt_result_d;
    end
  end

  // ==========================================================
  // conversion events
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      conversion_ready_q <= 1'b0;
    end else begin
      conversion_ready_q <= set_done;
    end
  end

  // either end of the range counts; clipped and exact codes look alike
  assign full_scale = shunt_code_in == monitor_pkg::shunt_full_scale_pos ||
                      shunt_code_in == monitor_pkg::shunt_full_scale_neg;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      adc_overflow_q <= 1'b0;
    end else begin
      adc_overflow_q <= shunt_sample && full_scale;
    end
  end

  assign conversion_ready_out = conversion_ready_q;
  assign adc_overflow_out = adc_overflow_q;
  // settled mode, not the one being written
  assign powered_down_out = config_q.mode[1:0] == 2'h0;
  assign conversion_busy_out = seq_busy;

  // ==========================================================
  // alert gating
  // R12 - per bit gate
  // R13 - bit 7 conversion ready
  // R14 - bit 6 adc overflow
  // R15 - bit 5 power-on-reset event
  // R16 - bit 4 communication fault or
  // R17 - bits 3:0 input warnings
  for (genvar b = 0; b < 8; b++) begin : g_alert_gate
    assign gated_flags[b] = vendor_status_flags_in[b] && !alert_mask_q[b];
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      alert_request_q <= 1'b0;
    end else begin
      alert_request_q <= |gated_flags;
    end
  end

  assign alert_request_out = alert_request_q;

  // ==========================================================
  // read answers
  // R1 - reads have no side effect
  // R11 - result returned raw, direct format
  always_comb begin
    read_data_d = monitor_pkg::read_zero;
    read_known = 1'b1;
    case (host_cmd_in.code)
      monitor_pkg::cmd_adc_configuration: begin
        read_data_d = config_q;
      end
      monitor_pkg::cmd_shunt_voltage_result: begin
        read_data_d = shunt_result_q;
      end
      monitor_pkg::cmd_alert_cause_mask: begin
        read_data_d = {8'h00, alert_mask_q};
      end
      default: begin
        read_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      answer_q <= '0;
    end else if (host_cmd_in.read) begin
      answer_q.valid <= 1'b1;
      answer_q.refused <= !read_known;
      answer_q.data <= read_data_d;
    end else if (host_cmd_in.write) begin
      // writes answer too: refused for result and unknown codes
      answer_q.valid <= 1'b1;
      answer_q.data <= monitor_pkg::read_zero;
      answer_q.refused <= !(config_write || mask_write);
    end else begin
      answer_q.valid <= 1'b0;
      answer_q.refused <= 1'b0;
    end
  end

  assign answer_out = answer_q;

  // ==========================================================
  // configuration view
  assign adc_config_out = config_q;

endmodule

// file: common/monitor_pkg.sv
// shared constants and types of the monitor adc configuration block
package monitor_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] cmd_adc_configuration = 8'hd0;
  localparam logic [7:0] cmd_shunt_voltage_result = 8'hd1;
  localparam logic [7:0] cmd_alert_cause_mask = 8'hd2;

  // ==========================================================
  // reset values and fixed fields
  localparam logic [15:0] adc_config_reset = 16'h4127;
  localparam logic [3:0] adc_config_fixed = 4'h4;
  localparam logic [15:0] shunt_result_reset = 16'h0000;
  localparam logic [7:0] alert_mask_reset = 8'hf0;
  localparam logic [15:0] shunt_full_scale_pos = 16'h7fff;
  localparam logic [15:0] shunt_full_scale_neg = 16'h8000;
  localparam logic [15:0] read_zero = 16'h0000;

  // ==========================================================
  // timing
  localparam int clk_period_ns = 8;
  localparam int conv_time_ns [8] = '{140000, 204000, 332000, 588000,
                                      1100000, 2116000, 4156000, 8244000};
  localparam logic [7:0][20:0] conv_cycles_default = '{
    21'(conv_time_ns[7] / clk_period_ns), 21'(conv_time_ns[6] / clk_period_ns),
    21'(conv_time_ns[5] / clk_period_ns), 21'(conv_time_ns[4] / clk_period_ns),
    21'(conv_time_ns[3] / clk_period_ns), 21'(conv_time_ns[2] / clk_period_ns),
    21'(conv_time_ns[1] / clk_period_ns), 21'(conv_time_ns[0] / clk_period_ns)};

  // log2 of samples averaged: 1,4,16,64,128,256,512,1024
  localparam logic [7:0][3:0] avg_shift_table = '{4'ha, 4'h9, 4'h8, 4'h7,
                                                  4'h6, 4'h4, 4'h2, 4'h0};

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    mode_off_a = 3'h0,
    mode_shunt_trig = 3'h1,
    mode_bus_trig = 3'h2,
    mode_both_trig = 3'h3,
    mode_off_b = 3'h4,
    mode_shunt_cont = 3'h5,
    mode_bus_cont = 3'h6,
    mode_both_cont = 3'h7
  } mode_type;

  typedef enum logic [1:0] {
    seq_idle = 2'h0,
    seq_shunt = 2'h1,
    seq_bus = 2'h3
  } seq_state_type;

  typedef struct packed {
    logic [3:0] fixed;
    logic [2:0] sample_averaging_count;
    logic [2:0] bus_conv_time;
    logic [2:0] shunt_conv_time;
    mode_type mode;
  } adc_config_type;

  typedef struct packed {
    logic pending;
    logic write;
    logic read;
    logic [7:0] code;
    logic [15:0] wdata;
  } host_cmd_type;

  typedef struct packed {
    logic valid;
    logic refused;
    logic [15:0] data;
  } read_answer_type;

endpackage

// file: rtl/conversion_sequencer.sv
// conversion timing and averaging round sequencer
`timescale 1ns/1ps
module conversion_sequencer #(
  parameter int CT_WIDTH = 21,
  parameter int ROUND_WIDTH = 11
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic restart_in,
  input wire logic halt_in,
  input wire logic run_in,
  input wire logic continuous_in,
  input wire logic do_shunt_in,
  input wire logic do_bus_in,
  input wire logic [CT_WIDTH-1:0] shunt_cycles_in,
  input wire logic [CT_WIDTH-1:0] bus_cycles_in,
  input wire logic [ROUND_WIDTH-1:0] rounds_in,
  output logic shunt_sample_out,
  output logic bus_sample_out,
  output logic set_done_out,
  output logic busy_out
);

  monitor_pkg::seq_state_type state_q;
  monitor_pkg::seq_state_type first_state;
  logic [CT_WIDTH-1:0] count_q;
  logic [ROUND_WIDTH-1:0] round_q;
  logic step;
  logic shunt_last;
  logic bus_last;
  logic round_end;
  logic last_round;

  // ==========================================================
  // stage decode
  assign step = !halt_in && !restart_in;
  assign shunt_last = state_q == monitor_pkg::seq_shunt &&
                      count_q == shunt_cycles_in - CT_WIDTH'(1);
  assign bus_last = state_q == monitor_pkg::seq_bus &&
                    count_q == bus_cycles_in - CT_WIDTH'(1);
  assign round_end = bus_last || (shunt_last && !do_bus_in);
  assign last_round = round_q == rounds_in - ROUND_WIDTH'(1);
  assign first_state = do_shunt_in ? monitor_pkg::seq_shunt : monitor_pkg::seq_bus;

  assign shunt_sample_out = step && shunt_last;
  assign bus_sample_out = step && bus_last;
  assign set_done_out = step && round_end && last_round;
  assign busy_out = state_q != monitor_pkg::seq_idle;

  // ==========================================================
  // state, count and round
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= monitor_pkg::seq_idle;
      count_q <= '0;
      round_q <= '0;
    end else if (restart_in) begin
      count_q <= '0;
      round_q <= '0;
      state_q <= run_in ? first_state : monitor_pkg::seq_idle;
    end else if (!halt_in) begin
      case (state_q)
        monitor_pkg::seq_idle: begin
          count_q <= '0;
        end
        monitor_pkg::seq_shunt, monitor_pkg::seq_bus: begin
          if (shunt_last || bus_last) begin
            count_q <= '0;
          end else begin
            count_q <= count_q + CT_WIDTH'(1);
          end
          if (shunt_last && do_bus_in) begin
            state_q <= monitor_pkg::seq_bus;
          end else if (round_end && last_round) begin
            round_q <= '0;
            state_q <= continuous_in ? first_state : monitor_pkg::seq_idle;
          end else if (round_end) begin
            round_q <= round_q + ROUND_WIDTH'(1);
            state_q <= first_state;
          end
        end
        default: begin
          state_q <= monitor_pkg::seq_idle;
        end
      endcase
    end
  end

endmodule

// file: bench/host_model.sv
// host side model issuing command reads and writes
`timescale 1ns/1ps
module host_model (
  input wire logic clk_in,
  output monitor_pkg::host_cmd_type host_cmd_out,
  input monitor_pkg::read_answer_type answer_in
);
  initial host_cmd_out = '0;
  // ==========
  // one command transfer
  // result word taken raw, direct format only
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output monitor_pkg::read_answer_type ans);
    @(posedge clk_in);
    #1;
    host_cmd_out.code = code;
    host_cmd_out.wdata = wd;
    host_cmd_out.pending = wr;
    // writes linger so the halt window is really exercised
    repeat (wr ? 3 : 1) @(posedge clk_in);
    #1;
    host_cmd_out.write = wr;
    host_cmd_out.read = !wr;
    @(posedge clk_in);
    #1;
    host_cmd_out = '0;
    host_cmd_out.code = ~code;
    host_cmd_out.wdata = ~wd;
    ans = answer_in;
  endtask
endmodule

// file: bench/monitor_adc_config_alert_mask_chk.sv
// assertion checker for the adc configuration and alert mask block
`timescale 1ns/1ps
module monitor_adc_config_alert_mask_chk #(
  parameter int SHUNT_WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input monitor_pkg::host_cmd_type host_cmd_in,
  input monitor_pkg::read_answer_type answer_out,
  input monitor_pkg::adc_config_type adc_config_out,
  input wire logic [SHUNT_WIDTH-1:0] shunt_code_in,
  input wire logic shunt_sample_out,
  input wire logic bus_sample_out,
  input wire logic conversion_ready_out,
  input wire logic adc_overflow_out,
  input wire logic powered_down_out,
  input wire logic [7:0] vendor_status_flags_in,
  input wire logic alert_request_out
);
  logic live_q;
  logic [7:0] mask_q;
  logic wr_only;
  assign wr_only = host_cmd_in.write && !host_cmd_in.read;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ==========
  // helper state
  // past values before this are reset leftovers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) live_q <= 1'b0;
    else live_q <= 1'b1;
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) mask_q <= 8'hf0;
    else if (wr_only && host_cmd_in.code == 8'hd2) mask_q <= host_cmd_in.wdata[7:0];
  end
  // ==========
  // properties
  property p_read_keeps;
    live_q && host_cmd_in.read && host_cmd_in.code == 8'hd0
      |=> $stable(adc_config_out) && answer_out.data == adc_config_out;
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("config read disturbed settings");
  property p_write_cfg;
    wr_only && host_cmd_in.code == 8'hd0
      |=> adc_config_out == {4'h4, $past(host_cmd_in.wdata[11:0])};
  endproperty
  a_write_cfg: assert property (p_write_cfg)
    else $error("config write not taken as expected");
  property p_halt;
    host_cmd_in.pending |-> !shunt_sample_out && !bus_sample_out;
  endproperty
  a_halt: assert property (p_halt)
    else $error("sample during write halt");
  property p_fixed;
    adc_config_out.fixed == 4'h4;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed config bits changed");
  property p_pdn;
    powered_down_out == (adc_config_out.mode[1:0] == 2'b00);
  endproperty
  a_pdn: assert property (p_pdn)
    else $error("power down flag wrong for mode");
  property p_ro;
    wr_only && host_cmd_in.code == 8'hd1 |=> answer_out.valid && answer_out.refused;
  endproperty
  a_ro: assert property (p_ro)
    else $error("result write not refused");
  property p_alert;
    live_q |=> alert_request_out == |($past(vendor_status_flags_in) & ~$past(mask_q));
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert gating wrong");
  property p_ready;
    conversion_ready_out |-> $past(shunt_sample_out || bus_sample_out);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready without a closing sample");
  property p_ovf;
    live_q && shunt_sample_out && (shunt_code_in == 16'h7fff || shunt_code_in == 16'h8000)
      |=> adc_overflow_out;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("full scale sample not flagged");
endmodule
bind monitor_adc_config_alert_mask monitor_adc_config_alert_mask_chk #(
  .SHUNT_WIDTH(SHUNT_WIDTH)) chk (.clk_in(clk_in), .reset_in(reset_in),
  .host_cmd_in(host_cmd_in), .answer_out(answer_out), .adc_config_out(adc_config_out),
  .shunt_code_in(shunt_code_in), .shunt_sample_out(shunt_sample_out),
  .bus_sample_out(bus_sample_out), .conversion_ready_out(conversion_ready_out),
  .adc_overflow_out(adc_overflow_out), .powered_down_out(powered_down_out),
  .vendor_status_flags_in(vendor_status_flags_in), .alert_request_out(alert_request_out));

// file: bench/monitor_adc_config_alert_mask_bench.sv
// self-checking bench of the adc configuration and alert mask block
`timescale 1ns/1ps
module monitor_adc_config_alert_mask_bench;
  // short conversion counts keep the run small
  localparam logic [7:0][20:0] cyc = '{21'd10, 21'd9, 21'd8, 21'd7,
                                       21'd6, 21'd5, 21'd4, 21'd3};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [15:0] shunt_code = 16'h0000;
  logic [7:0] flags = 8'h00;
  logic ovf_on = 1'b0;
  logic [1:0] idx = 2'h0;
  logic shunt_s, bus_s, ready, ovf, pdn, busy, alert;
  logic [3:0] pulses;
  monitor_pkg::host_cmd_type host_cmd;
  monitor_pkg::read_answer_type answer;
  monitor_pkg::adc_config_type cfg;
  int fails = 0;
  int total_checks = 0;
  int sh [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  // any four in a row sum to -12
  logic [15:0] tbl [4] = '{16'hfff7, 16'h0005, 16'hfff9, 16'hffff};
  assign pulses = {ovf, ready, bus_s, shunt_s};
  always #4 clk_in = ~clk_in;
  host_model host (.clk_in(clk_in), .host_cmd_out(host_cmd), .answer_in(answer));
  monitor_adc_config_alert_mask #(.CONV_CYCLES(cyc)) uut (.clk_in(clk_in),
    .reset_in(reset_in), .host_cmd_in(host_cmd), .answer_out(answer),
    .adc_config_out(cfg), .shunt_code_in(shunt_code), .shunt_sample_out(shunt_s),
    .bus_sample_out(bus_s), .conversion_ready_out(ready), .adc_overflow_out(ovf),
    .powered_down_out(pdn), .conversion_busy_out(busy),
    .vendor_status_flags_in(flags), .alert_request_out(alert));
  always @(posedge clk_in) begin
    if (shunt_s === 1'b1) begin
      #1;
      idx = idx + 2'h1;
      shunt_code = ovf_on ? 16'h8000 : tbl[idx];
    end
  end
  // ==========
  // shared tasks
  task automatic test_done();
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic rf, input logic [15:0] d);
    monitor_pkg::read_answer_type a;
    host.xfer(1'b0, c, 16'h0000, a);
    cmp(a, {1'b1, rf, d});
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic rf);
    monitor_pkg::read_answer_type a;
    host.xfer(1'b1, c, d, a);
    cmp({a.valid, a.refused, 16'h0000}, {1'b1, rf, 16'h0000});
  endtask
  task automatic wait_pulse(input int s, output int n);
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (pulses[s] !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      fails++;
      test_done();
    end
  endtask
  task automatic spacing(input int s, input int e);
    int n;
    wait_pulse(s, n);
    wait_pulse(s, n);
    cmp(18'(n), 18'(e));
  endtask
  task automatic chk_alert(input logic [7:0] f, input logic e);
    flags = f;
    repeat (2) @(posedge clk_in);
    #1;
    cmp(18'(alert), 18'(e));
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    cmp(18'(cfg), 18'h04127);
    rd(8'hd0, 1'b0, 16'h4127);
    rd(8'hd1, 1'b0, 16'h0000);
    rd(8'hd2, 1'b0, 16'h00f0);
    chk_alert(8'hf0, 1'b0);
    chk_alert(8'h0f, 1'b1);
  endtask
  task automatic t_access();
    wr(8'hd0, 16'hffff, 1'b0);
    rd(8'hd0, 1'b0, 16'h4fff);
    wr(8'hd1, 16'h1234, 1'b1);
    rd(8'hd1, 1'b0, 16'h0000);
    rd(8'hd7, 1'b1, 16'h0000);
  endtask
  task automatic t_alert();
    for (int i = 0; i < 8; i++) begin
      wr(8'hd2, 16'h0000, 1'b0);
      chk_alert(8'(1 << i), 1'b1);
      wr(8'hd2, 16'(1 << i), 1'b0);
      chk_alert(8'(1 << i), 1'b0);
    end
    rd(8'hd2, 1'b0, 16'h0080);
    flags = 8'h00;
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      wr(8'hd0, 16'h4000 | 16'(m), 1'b0);
      cmp(18'({pdn, busy}), 18'({m[1:0] == 2'b00, m[1:0] != 2'b00}));
    end
  endtask
  task automatic t_conv();
    logic [15:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {4'h4, 3'h0, 3'(c), 3'(c), 3'h5};
      wr(8'hd0, v, 1'b0);
      rd(8'hd0, 1'b0, v);
      spacing(0, int'(cyc[c]));
      wr(8'hd0, v + 16'h0001, 1'b0);
      spacing(1, int'(cyc[c]));
    end
  endtask
  task automatic t_avg();
    for (int a = 0; a < 8; a++) begin
      wr(8'hd0, {4'h4, 3'(a), 6'h00, 3'h5}, 1'b0);
      spacing(2, 3 << sh[a]);
      if (a > 0) rd(8'hd1, 1'b0, 16'hfffd);
    end
  endtask
  task automatic t_ovf();
    int n;
    ovf_on = 1'b1;
    wr(8'hd0, 16'h4005, 1'b0);
    wait_pulse(3, n);
    rd(8'hd1, 1'b0, 16'h8000);
    ovf_on = 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    t_reset();
    t_access();
    t_alert();
    t_modes();
    t_conv();
    t_avg();
    t_ovf();
    test_done();
  end
endmodule
